/* hw/tsi_switch_memory_core.sv */
// How it works
// - separate 16-bit input and output buses, 16-bit address bus, processor strobes
// - sample clock times all transfers; write address from counter, read address from address bus
// - messaging: latched address word replaces memory data on output bus
// - per-frame CRC of data-path contents; mismatch with last frame pulls flag low
// - data strobe falling while chip select low releases the change flag
// - processor accesses never raise the change flag; only data path counts
// - three mode pins pick one of eight modes, code 000 is first data memory
// - first data memory: writes at counter location, reads at address-bus location
// - precharge half-period is internal; capture and launch on rising clock edge
// - read address taken at slot's first edge, data out at next slot's first edge
// - output under two slots after input lands next frame, otherwise same frame
// - input taken at slot's last edge, written at counter location on next edge
// - pass-through enable high sends captured address lines onto output bus
// - 11-bit counter wraps after 2047 and clears on frame pulse
// - change flag is open drain: driven low on change, otherwise released
// - a timeslot is two clock periods long
`timescale 1ns/1ps
`default_nettype none

module tsi_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    // pointers wrap by overflow, so depth must be a power of two
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0] count;
        logic ready;
        logic valid;
        logic [WIDTH-1:0] head;
    } tsi_fifo_state_t;

    tsi_fifo_state_t st_q;
    tsi_fifo_state_t st_d;

    logic push;
    logic pop;

    assign push = in_valid_i && st_q.ready;
    assign pop = out_ready_i && st_q.valid;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wr] = in_data_i;
            st_d.wr = st_q.wr + 1'b1;
        end
        if (pop) begin
            st_d.rd = st_q.rd + 1'b1;
        end
        case ({push, pop})
            2'b10: st_d.count = st_q.count + 1'b1;
            2'b01: st_d.count = st_q.count - 1'b1;
            default: st_d.count = st_q.count;
        endcase
        // flags registered so both ready and valid come from flip-flops
        st_d.ready = st_d.count != (PW+1)'(DEPTH);
        st_d.valid = st_d.count != '0;
        // head word kept in a flop so the drain side sees no read mux
        st_d.head = st_d.mem[st_d.rd];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
            st_q.ready <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign in_ready_o = st_q.ready;
    assign out_valid_o = st_q.valid;
    assign out_data_o = st_q.head;

endmodule : tsi_fifo

module tsi_switch_memory_core
    import tsi_pkg::*;
#(
    parameter int MEM_DEPTH = MEM_WORDS,
    parameter int TAP_DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // frame timing
    input wire logic frame_pulse_n_i,
    // mode straps
    input wire logic mode_sel_hi_i,
    input wire logic mode_sel_mid_i,
    input wire logic mode_sel_lo_i,
    input wire logic address_passthrough_en_i,
    // data and address buses
    input wire logic [DATA_W-1:0] input_bus_i,
    input wire logic [ADDR_W-1:0] addr_bus_i,
    output logic [DATA_W-1:0] output_bus_o,
    // processor access strobes
    input wire logic chip_sel_n_i,
    input wire logic proc_data_strobe_n_i,
    input wire logic proc_read_write_n_i,
    // open-drain change flag
    output logic content_change_flag_n_o,
    output logic content_change_flag_oe_o,
    // buffered copy of the output stream
    output logic tap_valid_o,
    output logic [DATA_W-1:0] tap_data_o,
    input wire logic tap_ready_i,
    output logic tap_push_ready_o
);
    tsi_core_state_t st_q;
    tsi_core_state_t st_d;

    logic [DATA_W-1:0] mem_q [MEM_DEPTH];
    logic [DATA_W-1:0] rd_word;
    tsi_mode_t mode;
    logic dm1;
    logic slot_last;
    logic frame_end;
    logic [DATA_W-1:0] crc_next;

    // straps sampled as plain levels
    assign mode = tsi_mode_t'({mode_sel_hi_i, mode_sel_mid_i, mode_sel_lo_i});

    // strap decode: only the first data memory mode moves words through memory
    always_comb begin
        dm1 = 1'b0;
        case (mode)
            TSI_MODE_DATA_MEMORY_FIRST: begin
                dm1 = 1'b1;
            end
            TSI_MODE_DATA_MEMORY_DOUBLE_BUFFERED,
            TSI_MODE_CONNECT_MEMORY_FIRST,
            TSI_MODE_CONNECT_MEMORY_SECOND: begin
                dm1 = 1'b0;
            end
            TSI_MODE_COUNTER,
            TSI_MODE_EXTERNAL_ADDRESS,
            TSI_MODE_SHIFT_REGISTER,
            TSI_MODE_DATA_MEMORY_VARIABLE_RATE: begin
                dm1 = 1'b0;
            end
            default: begin
                dm1 = 1'b0;
            end
        endcase
    end

    assign slot_last = st_q.cnt[0];
    assign frame_end = !frame_pulse_n_i || st_q.cnt == CNT_MAX;
    assign rd_word = mem_q[st_q.rd_addr];

    always_comb begin
        st_d = st_q;
        st_d.push.valid = 1'b0;
        st_d.wr_en = 1'b0;
        crc_next = st_q.crc;

        // sequential counter
        if (frame_end) begin
            st_d.cnt = CNT_RESET;
        end else begin
            st_d.cnt = st_q.cnt + 1'b1;
        end

        if (slot_last) begin
            // last edge of the slot: take the input word
            if (dm1) begin
                st_d.in_word = input_bus_i;
                st_d.wr_addr = {1'b0, st_q.cnt[CNT_W-1:1]};
                st_d.wr_en = 1'b1;
            end
        end else begin
            // first edge of the slot: launch last slot's read, take new address
            if (address_passthrough_en_i) begin
                st_d.out_word = st_q.addr_lat;
            end else if (dm1) begin
                st_d.out_word = rd_word;
            end
            st_d.push.valid = address_passthrough_en_i || dm1;
            st_d.push.data = st_d.out_word;
            st_d.addr_lat = addr_bus_i;
            st_d.rd_addr = addr_bus_i[CNT_W-1:0];
        end

        // signature fed at capture, so each frame covers exactly its own slots;
        // feeding it at the write edge would carry the last slot into the next frame
        // and flag a false change after reset
        if (slot_last && dm1) begin
            crc_next = tsi_crc_step(st_q.crc, input_bus_i);
        end
        st_d.crc = crc_next;

        // release on strobe, but a change in the same cycle wins
        st_d.ds_prev = proc_data_strobe_n_i;
        if (!chip_sel_n_i && st_q.ds_prev && !proc_data_strobe_n_i) begin
            st_d.flag = 1'b0;
        end

        if (frame_end) begin
            if (st_q.crc_valid && crc_next != st_q.crc_prev) begin
                st_d.flag = 1'b1;
            end
            st_d.crc_prev = crc_next;
            st_d.crc_valid = dm1;
            st_d.crc = CRC_INIT;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
            st_q.cnt <= CNT_RESET;
            st_q.crc <= CRC_INIT;
            st_q.crc_prev <= CRC_INIT;
            st_q.ds_prev <= 1'b1;
            st_q.out_word <= WORD_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // storage array, no reset needed
    always_ff @(posedge clk_i) begin
        if (st_q.wr_en) begin
            mem_q[st_q.wr_addr] <= st_q.in_word;
        end
    end

    tsi_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(TAP_DEPTH)
    ) u_tap_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(st_q.push.valid),
        .in_data_i(st_q.push.data),
        .in_ready_o(tap_push_ready_o),
        .out_valid_o(tap_valid_o),
        .out_data_o(tap_data_o),
        .out_ready_i(tap_ready_i)
    );

    assign output_bus_o = st_q.out_word;
    assign content_change_flag_n_o = 1'b0;
    assign content_change_flag_oe_o = st_q.flag;

endmodule : tsi_switch_memory_core

`default_nettype wire

/* include/tsi_pkg.sv */
package tsi_pkg;

    // bus and memory geometry
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    localparam int CNT_W = 11;
    localparam int MEM_WORDS = 2048;
    localparam int FIFO_DEPTH = 16;

    // frame timing, in sample clock cycles
    localparam int FRAME_CYCLES = 2048;
    localparam int SLOT_CLKS = 2;
    localparam logic [CNT_W-1:0] CNT_MAX = 11'h7FF;
    localparam logic [CNT_W-1:0] CNT_RESET = 11'h000;

    // change detection
    localparam logic [DATA_W-1:0] CRC_POLY = 16'h1021;
    localparam logic [DATA_W-1:0] CRC_INIT = 16'hFFFF;
    localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;

    typedef enum logic [2:0] {
        TSI_MODE_DATA_MEMORY_FIRST = 3'h0,
        TSI_MODE_DATA_MEMORY_DOUBLE_BUFFERED = 3'h1,
        TSI_MODE_CONNECT_MEMORY_FIRST = 3'h2,
        TSI_MODE_CONNECT_MEMORY_SECOND = 3'h3,
        TSI_MODE_COUNTER = 3'h4,
        TSI_MODE_EXTERNAL_ADDRESS = 3'h5,
        TSI_MODE_SHIFT_REGISTER = 3'h6,
        TSI_MODE_DATA_MEMORY_VARIABLE_RATE = 3'h7
    } tsi_mode_t;

    // one word with its valid qualifier
    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } tsi_word_t;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [DATA_W-1:0] in_word;
        logic wr_en;
        logic [CNT_W-1:0] wr_addr;
        logic [CNT_W-1:0] rd_addr;
        logic [ADDR_W-1:0] addr_lat;
        logic [DATA_W-1:0] out_word;
        logic [DATA_W-1:0] crc;
        logic [DATA_W-1:0] crc_prev;
        logic crc_valid;
        logic flag;
        logic ds_prev;
        tsi_word_t push;
    } tsi_core_state_t;

    function automatic logic [DATA_W-1:0] tsi_crc_step(
        input logic [DATA_W-1:0] crc,
        input logic [DATA_W-1:0] word
    );
        logic [DATA_W-1:0] c;
        c = crc;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            if (c[DATA_W-1] ^ word[i]) begin
                c = {c[DATA_W-2:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[DATA_W-2:0], 1'b0};
            end
        end
        return c;
    endfunction : tsi_crc_step

endpackage : tsi_pkg

/* testbench/tsi_switch_memory_core_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module tsi_chk import tsi_pkg::*; (
    input wire logic clk_i, rst_n_i, frame_pulse_n_i, chip_sel_n_i,
    input wire logic mode_sel_hi_i, mode_sel_mid_i, mode_sel_lo_i,
    input wire logic address_passthrough_en_i, proc_data_strobe_n_i,
    input wire logic content_change_flag_n_o, content_change_flag_oe_o,
    input wire logic tap_valid_o, tap_ready_i,
    input wire logic [ADDR_W-1:0] addr_bus_i,
    input wire logic [DATA_W-1:0] output_bus_o, tap_data_o
);
    logic [CNT_W-1:0] c_q;
    logic ds_q;
    wire logic pt = address_passthrough_en_i;
    wire logic oe = content_change_flag_oe_o;
    wire logic m0 = !(mode_sel_hi_i || mode_sel_mid_i || mode_sel_lo_i);
    wire logic fend = !frame_pulse_n_i || c_q == CNT_MAX;
    wire logic clr = ds_q && !proc_data_strobe_n_i && !chip_sel_n_i;
    // mirror of the slot counter
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            c_q <= CNT_RESET;
            ds_q <= 1'b1;
        end else begin
            c_q <= frame_pulse_n_i ? c_q + 11'h001 : CNT_RESET;
            ds_q <= proc_data_strobe_n_i;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_hold; c_q[0] |=> $stable(output_bus_o); endproperty
    a_hold: assert property (p_hold) else $error("output moved mid slot");
    property p_pass;
        !c_q[0] && frame_pulse_n_i && pt ##1 frame_pulse_n_i && pt ##1 pt
        |=> output_bus_o == $past(addr_bus_i, 3);
    endproperty
    a_pass: assert property (p_pass) else $error("pass word wrong");
    property p_mode; !m0 && !pt |=> $stable(output_bus_o); endproperty
    a_mode: assert property (p_mode) else $error("output moved off mode");
    property p_od; content_change_flag_n_o == 1'b0; endproperty
    a_od: assert property (p_od) else $error("flag data not low");
    property p_set; $rose(oe) |-> $past(fend) || $past(fend, 2); endproperty
    a_set: assert property (p_set) else $error("flag set off frame end");
    property p_clr; clr && !fend |-> ##1 !oe; endproperty
    a_clr: assert property (p_clr) else $error("flag not released");
    property p_keep; $fell(oe) |-> $past(clr) || $past(clr, 2); endproperty
    a_keep: assert property (p_keep) else $error("flag dropped unasked");
    property p_tap; tap_valid_o && !tap_ready_i |=> tap_valid_o && $stable(tap_data_o); endproperty
    a_tap: assert property (p_tap) else $error("tap head lost in stall");
endmodule : tsi_chk
bind tsi_switch_memory_core tsi_chk tsi_chk_i (.*);
`default_nettype wire

/* testbench/tsi_far.sv */
`timescale 1ns/1ps
`default_nettype none
module tsi_far (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [9:0] off_i,
    input wire logic frz_i,
    output logic frame_pulse_n_o = 1'b1,
    output logic [15:0] in_o = 16'h0000,
    output logic [15:0] addr_o = 16'h0000,
    output logic [10:0] cnt_o,
    output logic [5:0] fr_o
);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_o <= 11'h000;
            fr_o <= 6'h00;
        end else begin
            cnt_o <= cnt_o + 11'h001;
            fr_o <= fr_o + {5'h00, &cnt_o};
        end
    end
    // drive at the falling edge for the next rising edge
    always @(negedge clk_i) begin
        frame_pulse_n_o <= !(&cnt_o);
        in_o <= {frz_i ? 6'h00 : fr_o, cnt_o[10:1]};
        addr_o <= {fr_o[4:0], 1'b0, cnt_o[10:1] - off_i};
    end
endmodule : tsi_far
`default_nettype wire

/* testbench/tsi_switch_memory_core_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tsi_switch_memory_core_tb_top;
    import tsi_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, pt = 1'b0, cs_n = 1'b1, ds_n = 1'b1, rw_n = 1'b1;
    logic rdy = 1'b1, frz = 1'b1, chk_on = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [9:0] off = 10'h002, j;
    logic [9:0] offs [4] = '{10'h002, 10'h000, 10'h001, 10'h005};
    logic [5:0] efr, fr;
    logic [15:0] s;
    wire logic fp_n, oe, tv, tpr;
    wire logic [15:0] ib, ab, ob, td;
    wire logic [10:0] cnt;
    int bad_count = 0, check_count = 0, cyc = 0;
    always #12.5 clk_i = !clk_i;
    tsi_far tsi_far_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .off_i(off), .frz_i(frz),
        .frame_pulse_n_o(fp_n), .in_o(ib), .addr_o(ab), .cnt_o(cnt), .fr_o(fr));
    tsi_switch_memory_core tsi_switch_memory_core_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .frame_pulse_n_i(fp_n), .mode_sel_hi_i(mode[2]), .mode_sel_mid_i(mode[1]),
        .mode_sel_lo_i(mode[0]), .address_passthrough_en_i(pt), .input_bus_i(ib),
        .addr_bus_i(ab), .output_bus_o(ob), .chip_sel_n_i(cs_n), .proc_data_strobe_n_i(ds_n),
        .proc_read_write_n_i(rw_n), .content_change_flag_n_o(), .content_change_flag_oe_o(oe),
        .tap_valid_o(tv), .tap_data_o(td), .tap_ready_i(rdy), .tap_push_ready_o(tpr));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test;
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic cy(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cy
    task automatic to_cnt(input logic [5:0] f, input logic [10:0] c);
        while (!(fr == f && cnt == c)) @(negedge clk_i);
    endtask : to_cnt
    task automatic strobe(input logic c, input logic w);
        cs_n = c;
        rw_n = w;
        cy(1);
        ds_n = 0;
        cy(2);
        ds_n = 1;
        cs_n = 1;
        rw_n = 1;
        cy(1);
    endtask : strobe
    // slot word seen after each first edge from slot 2 of the frame on
    always @(negedge clk_i) begin
        if (chk_on && cnt[0] && cnt[10:2] != 0) begin
            j = cnt[10:1] - 10'h001;
            // output slot is j+1, so an address offset of one is already two slots
            efr = (off >= 10'h001 && j >= off) ? fr : fr - 6'h01;
            chk(ob, pt ? {fr[4:0], 1'b0, j - off} : {efr, j - off});
        end
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 24000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        cy(6);
        chk(ob, 16'h0000);
        chk({14'h0, oe, tv}, 16'h0000);
        chk({15'h0, tpr}, 16'h0001);
        rst_n_i = 1'b1;
        to_cnt(2, 4);
        chk({15'h0, oe}, 16'h0000);
        strobe(0, 0);
        strobe(0, 0);
        to_cnt(3, 0);
        frz = 0;
        to_cnt(3, 20);
        chk({15'h0, oe}, 16'h0000);
        to_cnt(4, 0);
        chk_on = 1;
        to_cnt(4, 20);
        chk({15'h0, oe}, 16'h0001);
        strobe(1, 1);
        chk({15'h0, oe}, 16'h0001);
        strobe(0, 1);
        chk({15'h0, oe}, 16'h0000);
        for (int i = 1; i < 4; i++) begin
            to_cnt(6'(4 + i), 0);
            off = offs[i];
        end
        to_cnt(8, 0);
        pt = 1;
        to_cnt(9, 0);
        pt = 0;
        to_cnt(9, 8);
        s = ob;
        chk(td, s);
        rdy = 1'b0;
        cy(64);
        chk({15'h0, tpr}, 16'h0000);
        chk(td, s);
        rdy = 1'b1;
        cy(40);
        chk({15'h0, tpr}, 16'h0001);
        chk_on = 1'b0;
        // straps move only while the core is held in reset
        rst_n_i = 1'b0;
        mode = 3'h4;
        cy(2);
        chk(ob, 16'h0000);
        rst_n_i = 1'b1;
        pt = 1'b1;
        cy(8);
        pt = 1'b0;
        cy(2);
        s = ob;
        cy(20);
        chk(ob, s);
        end_of_test();
    end
endmodule : tsi_switch_memory_core_tb_top
`default_nettype wire
